// *** msr_pkg.sv ***
package msr_pkg;

   // ************************************************************
   // Clock and timing
   // ************************************************************
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned INT_PULSE_NS = 2500;
   localparam int unsigned INT_CYC = (INT_PULSE_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam int unsigned LP_SLOW_HZ = 10;
   localparam int unsigned LP_FAST_HZ = 160;
   localparam int unsigned LP_SLOW_CYC = CLK_HZ / LP_SLOW_HZ;
   localparam int unsigned LP_FAST_CYC = CLK_HZ / LP_FAST_HZ;

   // ************************************************************
   // Register offsets (byte addresses)
   // ************************************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TRIG = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_X = 8'h0C;
   localparam logic [7:0] OFS_Y = 8'h10;
   localparam logic [7:0] OFS_Z = 8'h14;
   localparam logic [7:0] OFS_TEMP = 8'h18;

   // ************************************************************
   // Control field positions and reset value
   // ************************************************************
   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned CTRL_RATE_BIT = 2;
   localparam int unsigned CTRL_CHSET_LSB = 3;
   localparam int unsigned CTRL_SR_BIT = 5;
   localparam int unsigned CTRL_INTEN_BIT = 6;
   localparam int unsigned CTRL_W = 7;
   localparam logic [6:0] CTRL_RST = 7'h40;
   localparam logic [31:0] DATA_RST = 32'h0000_0000;

   // Status field positions
   localparam int unsigned STAT_BUSY_BIT = 0;
   localparam int unsigned STAT_CHAN_LSB = 1;
   localparam int unsigned STAT_CNT_LSB = 16;

   // Temperature: only result bits 11..2 are visible
   localparam int unsigned TEMP_KEEP_LSB = 2;

   // ************************************************************
   // Enumerations
   // ************************************************************
   typedef enum logic [1:0] {
      MODE_POWER_DOWN,
      MODE_LOW_POWER,
      MODE_FAST,
      MODE_MASTER
   } msr_mode_e;

   typedef enum logic [1:0] {
      CHSET_XYZT,
      CHSET_XYZ,
      CHSET_XY,
      CHSET_RSVD
   } msr_chset_e;

   typedef enum logic [1:0] {
      CH_FIELD_X,
      CH_FIELD_Y,
      CH_FIELD_Z,
      CH_TEMP
   } msr_chan_e;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// *** msr_sync3.sv ***
`timescale 1ns/1ps
// Three-stage synchroniser; the level moves only when stages two and three agree
module msr_sync3 (
   input wire logic i_mclk, // System clock
   input wire logic i_rst, // Async reset, active high
   input wire logic i_pin, // Asynchronous input
   output logic o_level, // Filtered level
   output logic o_rise // One-cycle pulse on a filtered rising edge
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic level_r;
   logic rise_r;
   wire agree = (s2_r == s3_r);

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         level_r <= 1'b0;
         rise_r <= 1'b0;
      end else begin
         s1_r <= i_pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (agree) begin
            level_r <= s3_r;
         end
         rise_r <= agree & s3_r & ~level_r;
      end
   end

   assign o_level = level_r;
   assign o_rise = rise_r;
endmodule

// *** msr_readout.sv ***
`timescale 1ns/1ps
// What this block does
// R01: Temperature channel enabled at reset; software may drop it for faster cycles.
// R02: Temperature register shows result bits 11..2 only; reader appends two bits.
// R03: Power-down mode performs no measurement or conversion.
// R04: Low-power mode runs cycles periodically at 10 Hz or 160 Hz.
// R05: Fast mode converts continuously over the selected channel set.
// R06: Host in fast mode clocks bus at 800 kHz and syncs on interrupt.
// R07: Master-controlled mode starts a cycle only on host trigger.
// R08: End-of-conversion is an active-low pulse of typically 2.5 us when enabled.
// R09: Full range: host reads first value 30 to 50 us after pulse end.
// R10: Short range: host reads first value 42 to 70 us after pulse end.
// R11: Host completes each next read inside the consecutive-read window.
// R12: Serial slave accepts bit clocks up to 1000 kHz, typically 400 kHz.
// R13: Fast mode restarts a cycle immediately after the previous one completes.
// R14: Other modes start a cycle only on an internal or external trigger.
// R15: Channels convert X, Y, Z, temperature; disabled channels are never updated.
// R16: No end-of-conversion pulse while in power-down.
module msr_readout
   import msr_pkg::*;
#(
   parameter int unsigned LP_SLOW_CYCLES = LP_SLOW_CYC, // 10 Hz period in clocks
   parameter int unsigned LP_FAST_CYCLES = LP_FAST_CYC, // 160 Hz period in clocks
   parameter int unsigned RES_W = 12 // ADC result width
) (
   input wire logic i_mclk, // System clock, 50 MHz
   input wire logic i_rst, // Async reset, active high
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte enables
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   // Converter
   output logic o_adc_start, // Start one channel conversion, pulse
   output logic [1:0] o_adc_chan, // Channel being converted
   output logic o_short_range, // Short-range setting to the front end
   input wire logic i_adc_done, // Conversion finished, pulse
   input wire logic [RES_W-1:0] i_adc_result, // Conversion result, two's complement
   // Pins
   input wire logic i_ext_trig, // External trigger pin, asynchronous
   output logic o_int_n // End-of-conversion, active low
);

   // ************************************************************
   // Register state
   // ************************************************************
   logic [CTRL_W-1:0] ctrl_r;
   logic [RES_W-1:0] res_r [4];
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic [15:0] cyc_cnt_r;

   wire msr_mode_e mode = msr_mode_e'(ctrl_r[CTRL_MODE_LSB +: 2]);
   wire msr_chset_e chset = msr_chset_e'(ctrl_r[CTRL_CHSET_LSB +: 2]);
   wire rate_fast = ctrl_r[CTRL_RATE_BIT];
   wire int_en = ctrl_r[CTRL_INTEN_BIT];

   // ************************************************************
   // Write channel: address and data taken together
   // ************************************************************
   wire wr_take = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
   wire wr_ctrl = wr_take & (s_axi_awaddr == OFS_CTRL);
   wire wr_trig = wr_take & (s_axi_awaddr == OFS_TRIG);
   wire wr_ok = wr_ctrl | wr_trig;
   wire sw_trig = wr_trig & s_axi_wstrb[0] & s_axi_wdata[0];

   // Byte enables: only lane 0 holds control bits
   wire [CTRL_W-1:0] ctrl_wr_val = s_axi_wstrb[0] ? s_axi_wdata[CTRL_W-1:0] : ctrl_r;

   // Taken as soon as both are offered and no write response is still pending;
   // a master that offers them apart just waits, and no holding register is needed.
   assign s_axi_awready = wr_take; // R12
   assign s_axi_wready = wr_take;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         ctrl_r <= CTRL_RST; // R01
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= ctrl_wr_val; // R01
         end
         if (wr_take) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Read channel
   // ************************************************************
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CONV
   } msr_state_e;

   msr_state_e state_r;
   logic [1:0] chan_r;

   // One read at a time: a new address waits until the data is taken
   wire rd_take = s_axi_arvalid & ~rvalid_r;
   wire busy = (state_r == ST_CONV);
   wire [31:0] stat_word = {cyc_cnt_r, 13'h0000, chan_r, busy};
   wire [31:0] temp_word = {22'h00_0000, res_r[CH_TEMP][RES_W-1:TEMP_KEEP_LSB]}; // R02
   wire rd_hit_ctrl = (s_axi_araddr == OFS_CTRL);
   wire rd_hit_trig = (s_axi_araddr == OFS_TRIG);
   wire rd_hit_stat = (s_axi_araddr == OFS_STAT);
   wire rd_hit_x = (s_axi_araddr == OFS_X);
   wire rd_hit_y = (s_axi_araddr == OFS_Y);
   wire rd_hit_z = (s_axi_araddr == OFS_Z);
   wire rd_hit_t = (s_axi_araddr == OFS_TEMP);
   wire rd_hit = rd_hit_ctrl | rd_hit_trig | rd_hit_stat | rd_hit_x | rd_hit_y | rd_hit_z | rd_hit_t;
   // Field results are sign-extended so software reads a plain signed word
   wire [31:0] x_word = {{(32-RES_W){res_r[CH_FIELD_X][RES_W-1]}}, res_r[CH_FIELD_X]};
   wire [31:0] y_word = {{(32-RES_W){res_r[CH_FIELD_Y][RES_W-1]}}, res_r[CH_FIELD_Y]};
   wire [31:0] z_word = {{(32-RES_W){res_r[CH_FIELD_Z][RES_W-1]}}, res_r[CH_FIELD_Z]};
   // Unmapped offsets read as zero and answer with an error response
   wire [31:0] rd_mux =
      rd_hit_ctrl ? {25'h000_0000, ctrl_r} :
      rd_hit_stat ? stat_word :
      rd_hit_x ? x_word :
      rd_hit_y ? y_word :
      rd_hit_z ? z_word :
      rd_hit_t ? temp_word : 32'h0000_0000;

   assign s_axi_arready = rd_take;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         rvalid_r <= 1'b0;
         rdata_r <= DATA_RST;
         rresp_r <= RESP_OKAY;
      end else if (rd_take) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_mux;
         rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // ************************************************************
   // Trigger sources
   // ************************************************************
   logic ext_rise;

   msr_sync3 u_trig_sync (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_pin(i_ext_trig),
      .o_level(),
      .o_rise(ext_rise)
   );

   // Low-power wake timer; free-runs only in low-power mode. A tick that
   // lands while a cycle is still running is dropped rather than queued,
   // so a long channel set lowers the rate instead of piling up requests.
   logic [22:0] lp_cnt_r;
   wire [22:0] lp_period = rate_fast ? 23'(LP_FAST_CYCLES - 1) : 23'(LP_SLOW_CYCLES - 1);
   wire lp_tick = (mode == MODE_LOW_POWER) & (lp_cnt_r >= lp_period); // R04

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         lp_cnt_r <= 23'h00_0000;
      end else if (mode != MODE_LOW_POWER || lp_tick) begin
         lp_cnt_r <= 23'h00_0000;
      end else begin
         lp_cnt_r <= lp_cnt_r + 23'h00_0001;
      end
   end

   // Fast mode needs no trigger; low-power and master modes wait for one, power-down never starts
   wire trig_go =
      (mode == MODE_LOW_POWER) ? lp_tick : // R14
      (mode == MODE_MASTER) ? (sw_trig | ext_rise) : // R07
      1'b0;

   // ************************************************************
   // Measurement sequencer
   // ************************************************************
   // The spare channel-set code falls back to all four channels
   wire [1:0] last_chan =
      (chset == CHSET_XY) ? 2'(CH_FIELD_Y) :
      (chset == CHSET_XYZ) ? 2'(CH_FIELD_Z) : 2'(CH_TEMP); // R15
   wire pd = (mode == MODE_POWER_DOWN);
   wire conv_done = (state_r == ST_CONV) & i_adc_done & ~pd;
   wire cyc_end = conv_done & (chan_r == last_chan);
   wire start_idle = (state_r == ST_IDLE) & ((mode == MODE_FAST) | trig_go); // R13
   logic adc_start_r;

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         state_r <= ST_IDLE;
         chan_r <= 2'(CH_FIELD_X);
         adc_start_r <= 1'b0;
         cyc_cnt_r <= 16'h0000;
      end else begin
         adc_start_r <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (start_idle) begin
                  state_r <= ST_CONV;
                  chan_r <= 2'(CH_FIELD_X); // R15
                  adc_start_r <= 1'b1;
               end
            end
            ST_CONV: begin
               if (pd) begin
                  // A done that arrives after the abort is ignored, since
                  // only the converting state listens to the converter
                  state_r <= ST_IDLE; // R03
               end else if (cyc_end) begin
                  cyc_cnt_r <= cyc_cnt_r + 16'h0001;
                  chan_r <= 2'(CH_FIELD_X);
                  if (mode == MODE_FAST) begin // R05
                     adc_start_r <= 1'b1; // R13
                  end else begin
                     state_r <= ST_IDLE; // R14
                  end
               end else if (conv_done) begin
                  chan_r <= chan_r + 2'b01;
                  adc_start_r <= 1'b1;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   assign o_adc_start = adc_start_r;
   assign o_adc_chan = chan_r;
   assign o_short_range = ctrl_r[CTRL_SR_BIT];

   // Only the converted channel is written; disabled ones keep old data
   // One process per slot keeps every result word single-driven
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_res
         always_ff @(posedge i_mclk or posedge i_rst) begin
            if (i_rst) begin
               res_r[g] <= '0;
            end else if (conv_done && chan_r == 2'(g)) begin
               res_r[g] <= i_adc_result; // R15
            end
         end
      end
   endgenerate

   // ************************************************************
   // End-of-conversion pulse
   // ************************************************************
   // A new cycle end during a pulse restarts its length rather than
   // stretching two pulses together unnoticed.
   // Power-down releases the pin at once and cuts a running pulse short.
   logic [7:0] int_cnt_r;
   logic int_n_r;

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         int_cnt_r <= 8'h00;
         int_n_r <= 1'b1;
      end else if (pd) begin
         int_cnt_r <= 8'h00; // R16
         int_n_r <= 1'b1;
      end else if (cyc_end && int_en) begin
         int_cnt_r <= 8'(INT_CYC - 1); // R08
         int_n_r <= 1'b0;
      end else if (int_cnt_r != 8'h00) begin
         int_cnt_r <= int_cnt_r - 8'h01;
      end else begin
         int_n_r <= 1'b1; // R08
      end
   end

   assign o_int_n = int_n_r;

endmodule

// *** msr_adc_model.sv ***
`timescale 1ns/1ps
// ****
// Converter model: answers each start after a fixed latency
// ****
module msr_adc_model #(
   parameter int unsigned LAT = 6 // Conversion time in clocks
) (
   input wire logic i_mclk, // System clock
   input wire logic i_start, // Start pulse
   input wire logic [1:0] i_chan, // Channel to convert
   input wire logic i_flip, // Invert results
   output logic o_done, // Done pulse
   output logic [11:0] o_result // Result
);
   logic [11:0] tbl [4] = '{12'h123, 12'hF0F, 12'h7FF, 12'h6AD};
   int cnt = 0;
   logic [1:0] ch = 2'h0;
   always_ff @(posedge i_mclk) begin
      o_done <= 1'b0;
      if (i_start) begin
         cnt <= LAT;
         ch <= i_chan;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end else if (cnt == 1) begin
         cnt <= 0;
         o_done <= 1'b1;
      end
   end
   // Outside the done pulse the result is the inverted table entry, wrong on purpose; i_flip inverts it during the pulse
   assign o_result = o_done ? tbl[ch] ^ {12{i_flip}} : ~tbl[ch];
endmodule

// *** msr_readout_chk.sv ***
`timescale 1ns/1ps
// ****
// Port checker
// ****
module msr_readout_chk
   import msr_pkg::*;
(
   input wire logic i_mclk, // Clock
   input wire logic i_rst, // Reset
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   input wire logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Byte enables
   input wire logic [1:0] s_axi_bresp, // Write response
   input wire logic s_axi_bvalid, // Response valid
   input wire logic s_axi_bready, // Response ready
   input wire logic [31:0] s_axi_rdata, // Read data
   input wire logic s_axi_rvalid, // Read valid
   input wire logic s_axi_rready, // Read ready
   input wire logic o_adc_start, // Start pulse
   input wire logic [1:0] o_adc_chan, // Channel
   input wire logic i_adc_done, // Done pulse
   input wire logic o_int_n // End of conversion
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   logic [1:0] mode_r;
   logic [7:0] low_r;
   logic wtake;
   assign wtake = s_axi_awvalid && s_axi_awready;
   // Mode is shadowed from CTRL writes, since only ports are visible
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         mode_r <= 2'h0;
      end else if (wtake && s_axi_awaddr == OFS_CTRL && s_axi_wstrb[0]) begin
         mode_r <= s_axi_wdata[1:0];
      end
   end
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         low_r <= 8'h00;
      end else begin
         low_r <= o_int_n ? 8'h00 : low_r + 8'h01;
      end
   end
   sequence s_done_fast;
      mode_r == 2'h2 && i_adc_done && !wtake;
   endsequence
   chk_int_width: assert property ($rose(o_int_n) && mode_r[0] |-> low_r == 8'(INT_CYC))
      else $error("int pulse width wrong");
   chk_pd_quiet: assert property (mode_r == 2'h0 && $past(mode_r, 2) == 2'h0 |-> !o_adc_start && o_int_n)
      else $error("activity in power-down");
   chk_fast_next: assert property (s_done_fast |=> o_adc_start)
      else $error("fast mode did not continue");
   chk_chan_order: assert property (o_adc_start && o_adc_chan != 2'h0 |-> $past(o_adc_chan) == o_adc_chan - 2'h1)
      else $error("channel order broken");
   chk_start_pulse: assert property (o_adc_start |=> !o_adc_start)
      else $error("start longer than one cycle");
   chk_b_follows: assert property (wtake |=> s_axi_bvalid)
      else $error("no write response");
   chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
endmodule

bind msr_readout msr_readout_chk i_msr_readout_chk (.i_mclk, .i_rst, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .o_adc_start, .o_adc_chan, .i_adc_done, .o_int_n);

// *** tb_msr_readout.sv ***
`timescale 1ns/1ps
// ****
// Bench: register access through every mode
// ****
module tb_msr_readout;
   import msr_pkg::*;
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;
   logic i_mclk = 1'b0;
   logic i_rst = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic i_ext_trig = 1'b0;
   logic flip = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, o_adc_chan;
   logic [31:0] s_axi_rdata, rdat;
   logic o_adc_start, o_short_range, i_adc_done, o_int_n;
   logic [11:0] i_adc_result;
   logic [15:0] c0;
   int failures = 0;
   int checks = 0;
   msr_readout #(.LP_SLOW_CYCLES(600), .LP_FAST_CYCLES(200)) i_msr_readout (.i_mclk, .i_rst, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .o_adc_start, .o_adc_chan, .o_short_range, .i_adc_done,
      .i_adc_result, .i_ext_trig, .o_int_n);
   msr_adc_model i_msr_adc_model (.i_mclk, .i_start(o_adc_start), .i_chan(o_adc_chan), .i_flip(flip),
      .o_done(i_adc_done), .o_result(i_adc_result));
   initial begin
      forever #10 i_mclk = ~i_mclk;
   end
   task automatic wrap_up();
      if (failures == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic ok, input string s);
      checks++;
      if (ok !== 1'b1) begin
         failures++;
         $display("[ERR] %0t %s", $time, s);
      end
   endtask
   // Ready is raised one edge late so that the slave has to hold its answer
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge i_mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      @(negedge i_mclk);
      while (!s_axi_awready) @(negedge i_mclk);
      @(posedge i_mclk);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      @(posedge i_mclk);
      s_axi_bready <= 1'b1;
      @(negedge i_mclk);
      while (!s_axi_bvalid) @(negedge i_mclk);
      chk(s_axi_bresp === er, "write response");
      @(posedge i_mclk);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
      @(posedge i_mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      @(negedge i_mclk);
      while (!s_axi_arready) @(negedge i_mclk);
      @(posedge i_mclk);
      s_axi_arvalid <= 1'b0;
      @(posedge i_mclk);
      s_axi_rready <= 1'b1;
      @(negedge i_mclk);
      while (!s_axi_rvalid) @(negedge i_mclk);
      rdat = s_axi_rdata;
      chk(((rdat ^ e) & m) === 32'h0000_0000 && s_axi_rresp === er, "read data");
      @(posedge i_mclk);
      s_axi_rready <= 1'b0;
   endtask
   task automatic rdall(input logic [11:0] x, y, z, input logic [9:0] t, input logic [15:0] c);
      rd(OFS_X, {{20{x[11]}}, x}, ALL, RESP_OKAY);
      rd(OFS_Y, {{20{y[11]}}, y}, ALL, RESP_OKAY);
      rd(OFS_Z, {{20{z[11]}}, z}, ALL, RESP_OKAY);
      rd(OFS_TEMP, {22'h00_0000, t}, ALL, RESP_OKAY);
      rd(OFS_STAT, {c, 16'h0000}, 32'hFFFF_0007, RESP_OKAY);
   endtask
   task automatic wait_int();
      int n;
      n = 0;
      @(negedge i_mclk);
      while (o_int_n === 1'b1 && n < 3000) begin
         @(negedge i_mclk);
         n++;
      end
      n = 0;
      while (o_int_n === 1'b0) begin
         @(negedge i_mclk);
         n++;
      end
      chk(n == INT_CYC, "int width");
   endtask
   task automatic lp_run(input logic [31:0] ctl, input int span, input logic [15:0] lo, hi);
      wr(OFS_CTRL, ctl, RESP_OKAY);
      repeat (span) @(posedge i_mclk);
      wr(OFS_CTRL, 32'h0000_0040, RESP_OKAY);
      rd(OFS_STAT, 32'h0000_0000, 32'h0000_0000, RESP_OKAY);
      chk(rdat[31:16] - c0 >= lo && rdat[31:16] - c0 <= hi, "periodic rate");
      c0 = rdat[31:16];
   endtask
   initial begin
      repeat (20000) @(posedge i_mclk);
      failures++;
      wrap_up();
   end
   initial begin
      repeat (8) @(posedge i_mclk);
      i_rst <= 1'b0;
      rd(OFS_CTRL, 32'h0000_0040, ALL, RESP_OKAY);
      rd(8'h1C, 32'h0000_0000, ALL, RESP_SLVERR);
      wr(8'h1C, 32'h0000_0000, RESP_SLVERR);
      repeat (300) @(posedge i_mclk);
      rd(OFS_STAT, 32'h0000_0000, ALL, RESP_OKAY);
      wr(OFS_CTRL, 32'h0000_0043, RESP_OKAY);
      s_axi_wstrb <= 4'hE;
      wr(OFS_CTRL, 32'h0000_0040, RESP_OKAY);
      wr(OFS_TRIG, 32'h0000_0001, RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      rd(OFS_CTRL, 32'h0000_0043, ALL, RESP_OKAY);
      repeat (300) @(posedge i_mclk);
      rd(OFS_STAT, 32'h0000_0000, 32'hFFFF_0007, RESP_OKAY);
      wr(OFS_TRIG, 32'h0000_0001, RESP_OKAY);
      wait_int();
      rdall(12'h123, 12'hF0F, 12'h7FF, 10'h1AB, 16'h0001);
      wr(OFS_CTRL, 32'h0000_004B, RESP_OKAY);
      flip <= 1'b1;
      wr(OFS_TRIG, 32'h0000_0001, RESP_OKAY);
      wait_int();
      rdall(12'hEDC, 12'h0F0, 12'h800, 10'h1AB, 16'h0002);
      wr(OFS_CTRL, 32'h0000_0073, RESP_OKAY);
      chk(o_short_range === 1'b1, "range select");
      flip <= 1'b0;
      i_ext_trig <= 1'b1;
      repeat (8) @(posedge i_mclk);
      i_ext_trig <= 1'b0;
      wait_int();
      rdall(12'h123, 12'hF0F, 12'h800, 10'h1AB, 16'h0003);
      c0 = 16'h0003;
      lp_run(32'h0000_0052, 300, 16'h000A, 16'h0020);
      repeat (400) @(posedge i_mclk);
      rd(OFS_STAT, {c0, 16'h0000}, 32'hFFFF_0001, RESP_OKAY);
      lp_run(32'h0000_0045, 1000, 16'h0004, 16'h0006);
      lp_run(32'h0000_0041, 1200, 16'h0001, 16'h0003);
      wr(OFS_CTRL, 32'h0000_0013, RESP_OKAY);
      i_rst <= 1'b1;
      repeat (3) @(posedge i_mclk);
      i_rst <= 1'b0;
      rd(OFS_CTRL, 32'h0000_0040, ALL, RESP_OKAY);
      rd(OFS_STAT, 32'h0000_0000, ALL, RESP_OKAY);
      wrap_up();
   end
endmodule
